// ===== design/sac_consts.svh
// timing counts and widths for the conversion and power-mode control block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_CLK_PERIOD_NS 100
`define SAC_CONV_TIME_NS 650
`define SAC_CONV_CYCLES ((`SAC_CONV_TIME_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_PWRUP_TIME_US 100
`define SAC_PWRUP_CYCLES ((`SAC_PWRUP_TIME_US * 1000) / `SAC_CLK_PERIOD_NS)
`define SAC_RESULT_BITS 12
`define SAC_BUSY_EDGES 13
`endif

// ===== design/sac_pkg.sv
// types for the conversion and power-mode control block
package sac_pkg;
  typedef enum logic [3:0] {
    SAC_IDLE = 4'b0001,
    SAC_CONV = 4'b0010,
    SAC_DOWN = 4'b0100,
    SAC_WAKE = 4'b1000
  } sac_state_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] start_sync;
    logic [2:0] sclk_sync;
    sac_state_t state;
    logic [15:0] count;
    logic [11:0] shift;
    logic [3:0] edges;
    logic busy_en;
    logic drive;
    logic data;
    logic hold;
    logic powered;
    logic done;
  } sac_regs_t;
endpackage : sac_pkg

// ===== design/sac_conv_ctrl.sv
// conversion timing, power-mode selection and serial result readout
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_conv_ctrl #(
  parameter int unsigned RESULT_BITS = `SAC_RESULT_BITS,
  parameter int unsigned PWRUP_CYCLES = `SAC_PWRUP_CYCLES
) (
  input wire logic ref_clk_i, // block clock, 10 MHz
  input wire logic reset_n_i, // asynchronous reset, active low
  input wire logic conversion_start_n_i, // conversion start pin, active low
  input wire logic frame_select_n_i, // frame select pin, active low
  input wire logic serial_clk_i, // serial clock pin from the host
  input wire logic [11:0] sample_code_i, // straight binary code from the analog core
  output logic serial_data_o, // serial data output
  output logic serial_data_oe_o, // high while the data pin is driven
  output logic sample_hold_o, // high while the sampler holds
  output logic powered_o, // high while analog circuitry is powered
  output logic conv_done_o // one-cycle pulse at conversion end
);

  // derived constants sized to the registers they load
  // counts are loaded at the start and run down to one, so a count of n spans n cycles
  // the serial clock needs half periods longer than the three-cycle sync and edge delay
  localparam logic [15:0] CONV_CYC = 16'(`SAC_CONV_CYCLES); // conversion length
  localparam logic [15:0] WAKE_CYC = 16'(PWRUP_CYCLES); // wake length
  localparam logic [3:0] LAST_EDGE = 4'(RESULT_BITS); // final data edge index

  // all state lives in one packed struct
  sac_pkg::sac_regs_t r; // registered state
  sac_pkg::sac_regs_t next_r; // next state
  logic start_fall; // falling edge of conversion start
  logic start_rise; // rising edge of conversion start
  logic cs_fall; // frame opens
  logic cs_rise; // frame closes
  logic sclk_fall; // serial clock fall
  logic start_lvl; // synchronised start level
  logic cs_lvl; // synchronised frame-select level
  logic conv_begin; // start edge taken from idle this cycle

  // edge finding reads only the second and third stages
  always_comb
  begin
    start_lvl = r.start_sync[1];
    cs_lvl = r.cs_sync[1];
    start_fall = r.start_sync[2] & ~r.start_sync[1];
    start_rise = ~r.start_sync[2] & r.start_sync[1];
    cs_fall = r.cs_sync[2] & ~r.cs_sync[1];
    cs_rise = ~r.cs_sync[2] & r.cs_sync[1];
    sclk_fall = r.sclk_sync[2] & ~r.sclk_sync[1];
    // a start edge counts only while idle; elsewhere it is refused
    // a frame opened by that same edge belongs to the busy decision at the end
    conv_begin = start_fall & (r.state == sac_pkg::SAC_IDLE);
  end

  // next-state logic for control, counters and shifter
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    // pin levels shift through the synchronisers every cycle
    next_r.start_sync = {r.start_sync[1:0], conversion_start_n_i};
    next_r.cs_sync = {r.cs_sync[1:0], frame_select_n_i};
    next_r.sclk_sync = {r.sclk_sync[1:0], serial_clk_i};
    // control sequence: idle, converting, powered down, waking
    case (r.state)
      sac_pkg::SAC_IDLE:
      begin
        // a start fall while idle begins a conversion
        if (start_fall)
        begin
          next_r.state = sac_pkg::SAC_CONV;
          // the sampler holds from this edge until the count runs out
          next_r.hold = 1'b1;
          next_r.count = CONV_CYC;
        end
      end
      sac_pkg::SAC_CONV:
      begin
        // count down on the internal clock, not the serial clock
        if (r.count > 16'h0001)
        begin
          next_r.count = r.count - 16'h0001;
        end
        else
        begin
          // end of conversion: sampler back to tracking, result loaded, mode chosen
          next_r.count = 16'h0000;
          next_r.hold = 1'b0;
          next_r.done = 1'b1;
          next_r.shift = sample_code_i;
          next_r.edges = 4'h0;
          next_r.busy_en = ~cs_lvl;
          if (!start_lvl)
          begin
            next_r.state = sac_pkg::SAC_DOWN;
            next_r.powered = 1'b0;
          end
          else
          begin
            // start back high in time: stay fully powered
            next_r.state = sac_pkg::SAC_IDLE;
          end
          // busy mode: frame open at end drives low until first fall
          if (!cs_lvl)
          begin
            next_r.drive = 1'b1;
            next_r.data = 1'b0;
          end
        end
      end
      sac_pkg::SAC_DOWN:
      begin
        // analog side is off; only a rising start edge wakes it
        if (start_rise)
        begin
          next_r.state = sac_pkg::SAC_WAKE;
          // power returns at once; readiness waits for the count
          next_r.powered = 1'b1;
          next_r.count = WAKE_CYC;
        end
      end
      sac_pkg::SAC_WAKE:
      begin
        // starts are ignored until the wake count has run out
        if (r.count > 16'h0001)
        begin
          next_r.count = r.count - 16'h0001;
        end
        else
        begin
          next_r.count = 16'h0000;
          // ready again; the next start fall begins a conversion
          next_r.state = sac_pkg::SAC_IDLE;
        end
      end
      default:
      begin
        // an illegal code falls back to idle
        next_r.state = sac_pkg::SAC_IDLE;
      end
    endcase
    // readout runs in every state except conversion, power-down included
    if (r.state != sac_pkg::SAC_CONV)
    begin
      // frame close always releases the pin and ends busy mode
      if (cs_rise)
      begin
        next_r.drive = 1'b0;
        next_r.busy_en = 1'b0;
      end
      else if (cs_fall && !r.busy_en && !conv_begin)
      begin
        // a frame opened with a start stays quiet until the conversion ends
        // msb appears on the frame-select fall
        next_r.drive = 1'b1;
        next_r.data = r.shift[11];
        next_r.shift = {r.shift[10:0], 1'b0};
        next_r.edges = 4'h1;
      end
      // falls while the frame is closed or the pin released are ignored
      else if (sclk_fall && !cs_lvl && r.drive)
      begin
        // each fall moves the next bit; the edge after the lsb releases
        if (r.edges == (r.busy_en ? 4'(`SAC_BUSY_EDGES) - 4'h1 : LAST_EDGE))
        begin
          next_r.drive = 1'b0;
        end
        else
        begin
          next_r.data = r.shift[11];
          next_r.shift = {r.shift[10:0], 1'b0};
        end
        next_r.edges = r.edges + 4'h1;
      end
    end
  end

  // single state register
  // reset loads the idle start and frame-select levels and a low serial clock, so no false fall follows reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r <= '{cs_sync: 3'h7, start_sync: 3'h7, sclk_sync: 3'h0, state: sac_pkg::SAC_IDLE,
             count: 16'h0000, shift: 12'h000, edges: 4'h0, busy_en: 1'b0, drive: 1'b0,
             data: 1'b0, hold: 1'b0, powered: 1'b1, done: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  // data, hold, power and done outputs straight from flip-flops
  assign serial_data_o = r.data;
  // enable also follows the synchronised frame level so the pin lets go promptly
  assign serial_data_oe_o = r.drive & ~cs_lvl;
  assign sample_hold_o = r.hold;
  assign powered_o = r.powered;
  assign conv_done_o = r.done;

endmodule : sac_conv_ctrl

// ===== tb/sac_conv_ctrl_checker.sv
// port assertions for the conversion control block
`timescale 1ns/1ps
module sac_conv_ctrl_checker (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic conversion_start_n_i,
  input wire logic frame_select_n_i,
  input wire logic serial_clk_i,
  input wire logic [11:0] sample_code_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe_o,
  input wire logic sample_hold_o,
  input wire logic powered_o,
  input wire logic conv_done_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // start level held across a conversion end
  sequence s_lo; !conversion_start_n_i [*5] ##0 conv_done_o; endsequence
  sequence s_hi; conversion_start_n_i [*5] ##0 conv_done_o; endsequence
  AST_HOLD_LEN: assert property ($rose(sample_hold_o) |-> sample_hold_o [*7] ##1 !sample_hold_o)
    else $error("hold length");
  AST_DONE_END: assert property (conv_done_o == $fell(sample_hold_o))
    else $error("done not at end");
  AST_PD: assert property (s_lo |-> ##[0:1] !powered_o)
    else $error("no power-down");
  AST_NORM: assert property (s_hi |=> powered_o)
    else $error("left normal mode");
  AST_HOLD_CAUSE: assert property ($rose(sample_hold_o) |-> !$past(conversion_start_n_i, 2)
    && $past(conversion_start_n_i, 5))
    else $error("hold without start fall");
  AST_OE_OFF: assert property ($rose(frame_select_n_i) |-> ##[1:4] !serial_data_oe_o)
    else $error("data not released");
  AST_OE_ONLY: assert property (frame_select_n_i [*4] |-> !serial_data_oe_o)
    else $error("driven while deselected");
  AST_DATA_FALL: assert property (serial_data_oe_o && $past(serial_data_oe_o) && $changed(serial_data_o)
    |-> !$past(serial_clk_i) && !$past(serial_clk_i, 2))
    else $error("data moved off a clock fall");
  AST_QUIET_CONV: assert property (sample_hold_o |-> !serial_data_oe_o)
    else $error("data driven during conversion");
endmodule : sac_conv_ctrl_checker
bind sac_conv_ctrl sac_conv_ctrl_checker i_sac_conv_ctrl_checker (.*);

// ===== tb/sac_host_model.sv
// host model driving start, frame select and serial clock
`timescale 1ns/1ps
module sac_host_model (
  input wire logic ref_clk_i,
  input wire logic sdo_i,
  output logic start_n_o,
  output logic frame_n_o,
  output logic sclk_o
);
  initial {start_n_o, frame_n_o, sclk_o} = 3'b111; // idle high, clock only in bursts
  task wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt
  // pd keeps start low over the end, bsy lowers frame early
  task conv(input bit pd, input bit bsy);
    start_n_o <= 1'b0;
    frame_n_o <= !bsy;
    wt(3);
    if (!pd)
      start_n_o <= 1'b1;
    wt(12); // timer longer than a conversion
  endtask : conv
  // sample each bit just before the next clock fall
  task read(input bit bsy, output logic [11:0] w);
    frame_n_o <= 1'b0;
    wt(4);
    for (int i = 0; i < 12 + bsy; i++)
    begin
      w = {w[10:0], sdo_i};
      sclk_o <= 1'b0;
      wt(4);
      sclk_o <= 1'b1;
      wt(4);
    end
  endtask : read
  task stop();
    frame_n_o <= 1'b1;
    wt(20); // quiet time before a new start
  endtask : stop
  task wake(input int n);
    start_n_o <= 1'b1;
    wt(n); // wait n cycles after raising start; t_down waits 10 of the 20
  endtask : wake
endmodule : sac_host_model

// ===== tb/tb_top.sv
// testbench for the conversion control block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("wrong value t=%0t got %h", $time, a); end end
module tb_top;
  localparam int unsigned PWR = 20; // shortened wake count
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] code = 12'h000;
  logic [11:0] w;
  wire st_n, fr_n, sclk, sdo, oe, hold, pwr, done;
  wire sdo_w = oe ? sdo : 1'b1; // pull-up on the released line
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_done = 0; // conversion end pulses seen
  always #50 ref_clk_i = ~ref_clk_i;
  sac_conv_ctrl #(.PWRUP_CYCLES(PWR)) i_sac_conv_ctrl (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .conversion_start_n_i(st_n), .frame_select_n_i(fr_n), .serial_clk_i(sclk), .sample_code_i(code),
    .serial_data_o(sdo), .serial_data_oe_o(oe), .sample_hold_o(hold), .powered_o(pwr), .conv_done_o(done));
  sac_host_model i_sac_host_model (.ref_clk_i(ref_clk_i), .sdo_i(sdo_w), .start_n_o(st_n),
    .frame_n_o(fr_n), .sclk_o(sclk));
  task conclude();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // normal mode conversion and plain readout
  task t_normal();
    code <= 12'ha5c;
    i_sac_host_model.conv(1'b0, 1'b0);
    `CHK(pwr, 1'b1)
    i_sac_host_model.read(1'b0, w);
    `CHK(w, 12'ha5c)
    `CHK(oe, 1'b0)
    i_sac_host_model.stop();
  endtask : t_normal
  // power-down with busy readout, then wake and convert
  task t_down();
    code <= 12'h9e1;
    i_sac_host_model.conv(1'b1, 1'b1);
    `CHK(pwr, 1'b0)
    `CHK(sdo_w, 1'b0)
    code <= 12'h001;
    i_sac_host_model.read(1'b1, w);
    `CHK(w, 12'h9e1)
    `CHK(oe, 1'b0)
    i_sac_host_model.stop();
    i_sac_host_model.wake(10);
    `CHK(pwr, 1'b1)
    i_sac_host_model.conv(1'b0, 1'b0);
    `CHK(n_done, 2)
    i_sac_host_model.conv(1'b0, 1'b0);
    `CHK(n_done, 3)
    i_sac_host_model.read(1'b0, w);
    `CHK(w, 12'h001)
    i_sac_host_model.stop();
  endtask : t_down
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (done === 1'b1)
      n_done++;
    if (cyc == 4000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    t_normal();
    t_down();
    conclude();
  end
endmodule : tb_top
